/* hw/phy_pkt_pkg.sv */
// constants shared by both ends of the extended phy packet link
// assumes one 125 mhz clock on both ends; quadlet bit 31 is the first bit on the bus
package phy_pkt_pkg;
    localparam int CLK_PERIOD_NS = 8;
    // packet class identifier and field positions in the first quadlet
    localparam logic [1:0] PID_CONFIG = 2'h0;
    localparam logic [1:0] PID_SELFID = 2'h2;
    localparam int PID_LSB = 30;
    localparam int NODE_LSB = 24;
    localparam int FORCE_ROOT_BIT = 23;
    localparam int GAP_SET_BIT = 22;
    localparam int TYPE_LSB = 16;
    localparam int PAGE_LSB = 13;
    localparam int PORT_LSB = 9;
    localparam int REG_LSB = 0;
    localparam int CONF_OK_BIT = 3;
    // extended packet type codes
    localparam logic [3:0] EXT_PING = 4'h0;
    localparam logic [3:0] EXT_BASE_RD = 4'h1;
    localparam logic [3:0] EXT_BASE_REPLY = 4'h3;
    localparam logic [3:0] EXT_PAGED_RD = 4'h5;
    localparam logic [3:0] EXT_PAGED_REPLY = 4'h7;
    localparam logic [3:0] EXT_CMD = 4'h8;
    localparam logic [3:0] EXT_CONFIRM = 4'ha;
    localparam logic [3:0] EXT_RESUME = 4'hf;
    // paged registers start after the eight base registers
    localparam logic [3:0] PAGED_REG_BASE = 4'h8;
    // remote command codes
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_DISABLE = 3'h1;
    localparam logic [2:0] CMD_SUSPEND = 3'h2;
    localparam logic [2:0] CMD_CLR_FAULT = 3'h4;
    localparam logic [2:0] CMD_ENABLE = 3'h5;
    localparam logic [2:0] CMD_RESUME = 3'h6;
    // phy packet marker in the low half of the first quadlet
    localparam logic [15:0] MARKER = 16'h00e0;
    localparam logic [15:0] MARKER_MASK = 16'h00f0;
    localparam logic [15:0] MARKER_CLEAR = 16'h0000;
    // host transmit queue addresses
    localparam logic [7:0] TXQ_ADDR_FIRST = 8'h70;
    localparam logic [7:0] TXQ_ADDR_SECOND = 8'h78;
    // reply deadline default, longest time, so cycles round down
    localparam int RESPONSE_NS_DEFAULT = 1000;
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_READ = 2'b01,
        DEV_SEND0 = 2'b10,
        DEV_SEND1 = 2'b11
    } dev_state_t;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_SEND0 = 2'b01,
        HOST_SEND1 = 2'b10
    } host_state_t;
endpackage

/* hw/ext_pkt_if.sv */
// quadlet link between the link-layer end and the phy end
// assumes both ends share ref_clk_i; each direction is valid/ready per quadlet
`timescale 1ns/1ps
interface ext_pkt_if;
    logic down_valid;
    logic [31:0] down_data;
    logic down_ready;
    logic up_valid;
    logic [31:0] up_data;
    logic up_ready;
    modport dev (
        input down_valid,
        input down_data,
        output down_ready,
        output up_valid,
        output up_data,
        input up_ready
    );
    modport host (
        output down_valid,
        output down_data,
        input down_ready,
        input up_valid,
        input up_data,
        output up_ready
    );
endinterface

/* hw/pkt_pair_rx.sv */
// pairs incoming quadlets and checks the second against the inverse of the first
// assumes the quadlets of one packet arrive back to back in order
`timescale 1ns/1ps
module pkt_pair_rx (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // quadlet stream
    input wire logic q_valid_i,
    input wire logic [31:0] q_data_i,
    output logic q_ready_o,
    // control
    input wire logic enable_i,
    input wire logic flush_i,
    // checked packet
    output logic pkt_valid_o,
    output logic pkt_err_o,
    output logic [31:0] pkt_q0_o
);
    logic have_q0_q;
    logic take;

    assign q_ready_o = enable_i & ~flush_i;
    assign take = q_valid_i & q_ready_o;

    // first quadlet is held until its partner arrives
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            have_q0_q <= 1'b0;
            pkt_q0_o <= 32'h0000_0000;
        end else if (flush_i) begin
            have_q0_q <= 1'b0;
        end else if (take) begin
            have_q0_q <= ~have_q0_q;
            if (!have_q0_q) begin
                pkt_q0_o <= q_data_i;
            end
        end
    end

    // a bad pair is dropped whole; the sender must retry
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pkt_valid_o <= 1'b0;
            pkt_err_o <= 1'b0;
        end else begin
            pkt_valid_o <= take & have_q0_q & (q_data_i == ~pkt_q0_o);
            pkt_err_o <= take & have_q0_q & (q_data_i != ~pkt_q0_o);
        end
    end
endmodule // pkt_pair_rx

/* hw/ext_pkt_dev.sv */
// phy end: decodes ping, remote access, remote command and resume packets
// assumes the local phy register file answers reg_data_i in the cycle of reg_rd_o
// Behaviour
// - ping to us returns current self-id
// - type zero means ping
// - reply starts before response deadline
// - second quadlet is inverse of first
// - remote access returns register value reply
// - type 1h base read, 5h paged
// - packet page and port replace selectors
// - base read addresses first eight registers
// - paged address is 1000b plus reg
// - command executes, then confirmation sent
// - type 8h means remote command
// - port field selects command target port
// - codes 0 nop, 1 disable, 2 suspend
// - codes 4 clear fault, 5 enable, 6 resume
// - resume packet wakes connected suspended ports
// - same as setting resume variable true
// - resume is broadcast, never answered
// - type fh means resume
// - config packet without r and t is extended
// - host writes quadlets at 70h then 78h
// - marker 00e0h replaced by zero before phy
`timescale 1ns/1ps
module ext_pkt_dev #(
    parameter int NPORTS = 3,
    parameter int RESPONSE_NS = phy_pkt_pkg::RESPONSE_NS_DEFAULT
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // link to the link-layer end
    ext_pkt_if.dev link,
    // node state
    input wire logic [5:0] node_id_i,
    input wire logic bus_reset_i,
    input wire logic [23:0] selfid_info_i,
    // phy register read port
    output logic reg_rd_o,
    output logic [3:0] reg_addr_o,
    output logic [2:0] reg_page_o,
    output logic [3:0] reg_port_o,
    input wire logic [7:0] reg_data_i,
    // port status
    input wire logic [NPORTS-1:0] port_connected_i,
    input wire logic [NPORTS-1:0] port_suspended_i,
    // port actions, one-cycle pulses
    output logic [NPORTS-1:0] disable_notification_o,
    output logic [NPORTS-1:0] port_disable_o,
    output logic [NPORTS-1:0] suspend_init_o,
    output logic [NPORTS-1:0] fault_clear_o,
    output logic [NPORTS-1:0] port_enable_o,
    output logic [NPORTS-1:0] port_resume_o,
    // diagnostics, one-cycle pulses
    output logic pair_err_o,
    output logic late_drop_o
);
    localparam int RESP_CYC_RAW = RESPONSE_NS / phy_pkt_pkg::CLK_PERIOD_NS;
    localparam int RESP_CYC = (RESP_CYC_RAW < 1) ? 1 : RESP_CYC_RAW;
    localparam int DW = $clog2(RESP_CYC + 1);

    phy_pkt_pkg::dev_state_t state_q;
    logic pkt_valid;
    logic [31:0] pkt_q0;
    logic [31:0] reply_q;
    logic [DW-1:0] deadline_q;
    logic [NPORTS-1:0] port_hit;
    logic [3:0] ptype;
    logic [3:0] pport;
    logic [2:0] pcmd;
    logic ext_pkt;
    logic addressed;
    logic is_ping;
    logic is_read;
    logic is_cmd;
    logic is_resume;
    logic cmd_ok;
    logic deadline_hit;

    // pairing and integrity check; only listens while idle
    pkt_pair_rx u_pair (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .q_valid_i(link.down_valid),
        .q_data_i(link.down_data),
        .q_ready_o(link.down_ready),
        .enable_i(state_q == phy_pkt_pkg::DEV_IDLE),
        .flush_i(bus_reset_i),
        .pkt_valid_o(pkt_valid),
        .pkt_err_o(pair_err_o),
        .pkt_q0_o(pkt_q0)
    );

    // field decode of the checked first quadlet
    assign ptype = pkt_q0[phy_pkt_pkg::TYPE_LSB +: 4];
    assign pport = pkt_q0[phy_pkt_pkg::PORT_LSB +: 4];
    assign pcmd = pkt_q0[phy_pkt_pkg::REG_LSB +: 3];
    // configuration class with r and t both clear is never a config packet
    assign ext_pkt = pkt_valid
        & (pkt_q0[phy_pkt_pkg::PID_LSB +: 2] == phy_pkt_pkg::PID_CONFIG)
        & ~pkt_q0[phy_pkt_pkg::FORCE_ROOT_BIT]
        & ~pkt_q0[phy_pkt_pkg::GAP_SET_BIT];
    assign addressed = (pkt_q0[phy_pkt_pkg::NODE_LSB +: 6] == node_id_i);
    assign is_ping = ext_pkt & addressed & (ptype == phy_pkt_pkg::EXT_PING);
    assign is_read = ext_pkt & addressed
        & ((ptype == phy_pkt_pkg::EXT_BASE_RD) | (ptype == phy_pkt_pkg::EXT_PAGED_RD));
    assign is_cmd = ext_pkt & addressed & (ptype == phy_pkt_pkg::EXT_CMD);
    // resume ignores the node identifier
    assign is_resume = ext_pkt & (ptype == phy_pkt_pkg::EXT_RESUME);
    // reserved codes and ports we do not have are confirmed as not done
    assign cmd_ok = (pport < 4'(NPORTS)) & (pcmd != 3'h3) & (pcmd != 3'h7);

    // one-hot target port of a remote command
    genvar gi;
    generate
        for (gi = 0; gi < NPORTS; gi++) begin : g_port
            assign port_hit[gi] = is_cmd & (pport == 4'(gi));
        end
    endgenerate

    // reply sequencer; bus reset abandons any reply in flight
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= phy_pkt_pkg::DEV_IDLE;
        end else if (bus_reset_i) begin
            state_q <= phy_pkt_pkg::DEV_IDLE;
        end else begin
            case (state_q)
                phy_pkt_pkg::DEV_IDLE: begin
                    if (is_read) begin
                        state_q <= phy_pkt_pkg::DEV_READ;
                    end else if (is_ping || is_cmd) begin
                        state_q <= phy_pkt_pkg::DEV_SEND0;
                    end
                end
                phy_pkt_pkg::DEV_READ: begin
                    state_q <= phy_pkt_pkg::DEV_SEND0;
                end
                phy_pkt_pkg::DEV_SEND0: begin
                    if (link.up_ready) begin
                        state_q <= phy_pkt_pkg::DEV_SEND1;
                    end else if (deadline_hit) begin
                        state_q <= phy_pkt_pkg::DEV_IDLE;
                    end
                end
                phy_pkt_pkg::DEV_SEND1: begin
                    if (link.up_ready) begin
                        state_q <= phy_pkt_pkg::DEV_IDLE;
                    end
                end
                default: begin
                    state_q <= phy_pkt_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // reply word; self-id is built from the live status, not the last one
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reply_q <= 32'h0000_0000;
        end else if (state_q == phy_pkt_pkg::DEV_IDLE) begin
            if (is_ping) begin
                reply_q <= {phy_pkt_pkg::PID_SELFID, node_id_i, selfid_info_i};
            end else if (is_cmd) begin
                reply_q <= pkt_q0;
                reply_q[phy_pkt_pkg::TYPE_LSB +: 4] <= phy_pkt_pkg::EXT_CONFIRM;
                reply_q[phy_pkt_pkg::CONF_OK_BIT] <= cmd_ok;
                reply_q[7:4] <= 4'h0;
            end
        end else if (state_q == phy_pkt_pkg::DEV_READ) begin
            reply_q <= {phy_pkt_pkg::PID_CONFIG, node_id_i, 4'h0,
                (ptype == phy_pkt_pkg::EXT_BASE_RD) ? phy_pkt_pkg::EXT_BASE_REPLY
                                                    : phy_pkt_pkg::EXT_PAGED_REPLY,
                reg_page_o, reg_port_o, 1'b0, reg_data_i};
        end
    end

    // register read request; packet fields stand in for the local selectors
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_addr_o <= 4'h0;
            reg_page_o <= 3'h0;
            reg_port_o <= 4'h0;
        end else if (is_read && state_q == phy_pkt_pkg::DEV_IDLE) begin
            reg_page_o <= pkt_q0[phy_pkt_pkg::PAGE_LSB +: 3];
            reg_port_o <= pport;
            if (ptype == phy_pkt_pkg::EXT_BASE_RD) begin
                reg_addr_o <= {1'b0, pcmd};
            end else begin
                reg_addr_o <= phy_pkt_pkg::PAGED_REG_BASE + {1'b0, pcmd};
            end
        end
    end
    assign reg_rd_o = (state_q == phy_pkt_pkg::DEV_READ);

    // deadline counter: a reply that cannot start in time is worthless
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            deadline_q <= '0;
        end else if (state_q == phy_pkt_pkg::DEV_IDLE) begin
            deadline_q <= DW'(RESP_CYC - 1);
        end else if (deadline_q != '0) begin
            deadline_q <= deadline_q - 1'b1;
        end
    end
    assign deadline_hit = (deadline_q == '0);

    // answer out on the link, second quadlet inverted
    assign link.up_valid = (state_q == phy_pkt_pkg::DEV_SEND0)
                         | (state_q == phy_pkt_pkg::DEV_SEND1);
    assign link.up_data = (state_q == phy_pkt_pkg::DEV_SEND1) ? ~reply_q : reply_q;

    // port actions; disable waits one cycle behind its notification
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            disable_notification_o <= '0;
            port_disable_o <= '0;
            suspend_init_o <= '0;
            fault_clear_o <= '0;
            port_enable_o <= '0;
            port_resume_o <= '0;
        end else begin
            disable_notification_o <= (pcmd == phy_pkt_pkg::CMD_DISABLE) ? port_hit : '0;
            port_disable_o <= disable_notification_o;
            suspend_init_o <= (pcmd == phy_pkt_pkg::CMD_SUSPEND) ? port_hit : '0;
            fault_clear_o <= (pcmd == phy_pkt_pkg::CMD_CLR_FAULT) ? port_hit : '0;
            port_enable_o <= (pcmd == phy_pkt_pkg::CMD_ENABLE) ? port_hit : '0;
            // resume packet raises the resume variable of each eligible port, no reply
            port_resume_o <= ((pcmd == phy_pkt_pkg::CMD_RESUME) ? port_hit : '0)
                | ({NPORTS{is_resume}} & port_connected_i & port_suspended_i);
        end
    end

    // reply dropped: far end held off past the deadline
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            late_drop_o <= 1'b0;
        end else begin
            late_drop_o <= (state_q == phy_pkt_pkg::DEV_SEND0) & ~link.up_ready
                         & deadline_hit & ~bus_reset_i;
        end
    end
endmodule // ext_pkt_dev

/* hw/ext_pkt_host.sv */
// link-layer end: transmit queue writes become packets, replies handed up
// assumes software writes the first quadlet at 70h before the second at 78h
`timescale 1ns/1ps
module ext_pkt_host (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // link to the phy end
    ext_pkt_if.host link,
    // transmit queue write port
    input wire logic wr_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [31:0] wr_data_i,
    output logic wr_ready_o,
    output logic wr_reject_o,
    // received quadlets
    output logic rx_valid_o,
    output logic [31:0] rx_data_o,
    input wire logic rx_ready_i
);
    phy_pkt_pkg::host_state_t state_q;
    logic have_first_q;
    logic [31:0] first_q;
    logic [31:0] wire_q0_q;
    logic [31:0] stripped;
    logic wr_first;
    logic wr_second;
    logic pair_ok;

    assign wr_ready_o = (state_q == phy_pkt_pkg::HOST_IDLE);
    assign wr_first = wr_i & wr_ready_o & (wr_addr_i == phy_pkt_pkg::TXQ_ADDR_FIRST);
    assign wr_second = wr_i & wr_ready_o & (wr_addr_i == phy_pkt_pkg::TXQ_ADDR_SECOND);
    assign pair_ok = have_first_q & (wr_data_i == ~first_q);
    // marker goes to zero so the phy sees a clean packet
    assign stripped = ((first_q[15:0] & phy_pkt_pkg::MARKER_MASK) == phy_pkt_pkg::MARKER)
        ? {first_q[31:16], first_q[15:0] & ~phy_pkt_pkg::MARKER_MASK | phy_pkt_pkg::MARKER_CLEAR}
        : first_q;

    // first quadlet store; a second write without a first is refused
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            have_first_q <= 1'b0;
            first_q <= 32'h0000_0000;
            wire_q0_q <= 32'h0000_0000;
            wr_reject_o <= 1'b0;
        end else begin
            wr_reject_o <= wr_second & ~pair_ok;
            if (wr_first) begin
                have_first_q <= 1'b1;
                first_q <= wr_data_i;
            end else if (wr_second) begin
                have_first_q <= 1'b0;
                wire_q0_q <= stripped;
            end
        end
    end

    // send both quadlets, the second recomputed after the marker swap
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= phy_pkt_pkg::HOST_IDLE;
        end else begin
            case (state_q)
                phy_pkt_pkg::HOST_IDLE: begin
                    if (wr_second && pair_ok) begin
                        state_q <= phy_pkt_pkg::HOST_SEND0;
                    end
                end
                phy_pkt_pkg::HOST_SEND0: begin
                    if (link.down_ready) begin
                        state_q <= phy_pkt_pkg::HOST_SEND1;
                    end
                end
                phy_pkt_pkg::HOST_SEND1: begin
                    if (link.down_ready) begin
                        state_q <= phy_pkt_pkg::HOST_IDLE;
                    end
                end
                default: begin
                    state_q <= phy_pkt_pkg::HOST_IDLE;
                end
            endcase
        end
    end
    assign link.down_valid = (state_q != phy_pkt_pkg::HOST_IDLE);
    assign link.down_data = (state_q == phy_pkt_pkg::HOST_SEND1) ? ~wire_q0_q : wire_q0_q;

    // one-quadlet holding stage for replies; stalls the phy while full
    assign link.up_ready = ~rx_valid_o;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= 32'h0000_0000;
        end else if (link.up_valid && !rx_valid_o) begin
            rx_valid_o <= 1'b1;
            rx_data_o <= link.up_data;
        end else if (rx_ready_i) begin
            rx_valid_o <= 1'b0;
        end
    end
endmodule // ext_pkt_host

/* verification/ext_pkt_props.sv */
// interface checker for the quadlet link between the two ends
// assumes one clock and an active-high async reset shared by both ends
`timescale 1ns/1ps
module ext_pkt_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // link signals
    input wire logic down_valid,
    input wire logic [31:0] down_data,
    input wire logic down_ready,
    input wire logic up_valid,
    input wire logic [31:0] up_data,
    input wire logic up_ready
);
    logic dn_second_q;
    logic up_second_q;
    logic [31:0] dn_first_q;
    logic [31:0] up_first_q;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // first quadlet of each pair, kept to check its partner and replies
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dn_second_q <= 1'b0;
            dn_first_q <= 32'h0;
            up_second_q <= 1'b0;
            up_first_q <= 32'h0;
        end else begin
            if (down_valid && down_ready) begin
                dn_second_q <= ~dn_second_q;
                if (!dn_second_q) dn_first_q <= down_data;
            end
            if (up_valid && up_ready) begin
                up_second_q <= ~up_second_q;
                if (!up_second_q) up_first_q <= up_data;
            end
        end
    end
    a_down_hold: assert property (down_valid && !down_ready |=> down_valid && $stable(down_data))
        else $error("down quadlet unstable");
    a_up_hold: assert property (up_valid && !up_ready |=> up_valid && $stable(up_data))
        else $error("reply quadlet unstable");
    a_down_pair_inv: assert property (down_valid && down_ready && dn_second_q |-> down_data == ~dn_first_q)
        else $error("down pair not inverse");
    a_up_pair_inv: assert property (up_valid && up_ready && up_second_q |-> up_data == ~up_first_q)
        else $error("reply pair not inverse");
    a_marker_clr: assert property (down_valid && !dn_second_q |-> down_data[7:4] != 4'he)
        else $error("marker not cleared");
    a_resume_quiet: assert property (down_valid && down_ready && dn_second_q &&
        dn_first_q[19:16] == phy_pkt_pkg::EXT_RESUME |=> !up_valid [*6])
        else $error("reply sent for resume");
    a_ping_reply: assert property ($rose(up_valid) && up_data[31:30] == 2'b10 |->
        dn_first_q[19:16] == phy_pkt_pkg::EXT_PING && up_data[29:24] == dn_first_q[29:24])
        else $error("stray self id");
    a_paged_reply: assert property ($rose(up_valid) && up_data[31:30] == 2'b00 &&
        up_data[19:16] == phy_pkt_pkg::EXT_PAGED_REPLY |->
        dn_first_q[19:16] == phy_pkt_pkg::EXT_PAGED_RD && up_data[15:9] == dn_first_q[15:9])
        else $error("paged reply mismatch");
    a_cmd_confirm: assert property ($rose(up_valid) && up_data[31:30] == 2'b00 &&
        up_data[19:16] == phy_pkt_pkg::EXT_CONFIRM |-> dn_first_q[19:16] == phy_pkt_pkg::EXT_CMD
        && up_data[12:9] == dn_first_q[12:9] && up_data[2:0] == dn_first_q[2:0])
        else $error("confirm mismatch");
endmodule // ext_pkt_props

/* verification/testbench.sv */
// both ends joined back to back; bench drives host writes and phy node state
// assumes the phy register file answers combinationally
`timescale 1ns/1ps
module testbench;
    localparam int DL = phy_pkt_pkg::RESPONSE_NS_DEFAULT / phy_pkt_pkg::CLK_PERIOD_NS;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rx_ready_i = 1'b0;
    logic wr_ready_o, wr_reject_o, rx_valid_o, late_drop_o;
    logic [7:0] wr_addr_i = 8'h00, reg_data_i;
    logic [31:0] wr_data_i = 32'h0, rx_data_o;
    logic [5:0] node_id_i = 6'h2a;
    logic [23:0] selfid_info_i = 24'h5a3c81;
    logic [3:0] reg_addr_o, reg_port_o;
    logic [2:0] reg_page_o, dn, dis, sus, fc, en, res;
    logic [2:0] port_connected_i = 3'h6, port_suspended_i = 3'h3;
    logic [19:0] acc = 20'h0;
    int n_errors = 0, total_checks = 0, cycles = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    // register model: value encodes page, port and address
    assign reg_data_i = {reg_port_o[1:0], reg_page_o[1:0], reg_addr_o};
    // pulse outputs are collected so slow tasks miss none
    always @(posedge ref_clk_i) acc <= acc | {late_drop_o, wr_reject_o, dn, dis, sus, fc, en, res};
    // hang guard
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end
    ext_pkt_if u_ext_pkt_if ();
    ext_pkt_host u_ext_pkt_host (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .link(u_ext_pkt_if.host), .wr_i(wr_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
        .wr_ready_o(wr_ready_o), .wr_reject_o(wr_reject_o), .rx_valid_o(rx_valid_o),
        .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i));
    ext_pkt_dev u_ext_pkt_dev (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .link(u_ext_pkt_if.dev), .node_id_i(node_id_i), .bus_reset_i(1'b0),
        .selfid_info_i(selfid_info_i), .reg_rd_o(), .reg_addr_o(reg_addr_o),
        .reg_page_o(reg_page_o), .reg_port_o(reg_port_o), .reg_data_i(reg_data_i),
        .port_connected_i(port_connected_i), .port_suspended_i(port_suspended_i),
        .disable_notification_o(dn), .port_disable_o(dis), .suspend_init_o(sus),
        .fault_clear_o(fc), .port_enable_o(en), .port_resume_o(res), .pair_err_o(),
        .late_drop_o(late_drop_o));
    ext_pkt_props u_ext_pkt_props (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .down_valid(u_ext_pkt_if.down_valid), .down_data(u_ext_pkt_if.down_data),
        .down_ready(u_ext_pkt_if.down_ready), .up_valid(u_ext_pkt_if.up_valid),
        .up_data(u_ext_pkt_if.up_data), .up_ready(u_ext_pkt_if.up_ready));
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    function automatic logic [31:0] mk(input logic [5:0] nd, input logic [3:0] t,
        input logic [2:0] pg, input logic [3:0] pt, input logic [2:0] lo);
        return {2'h0, nd, 4'h0, t, pg, pt, 1'b0, 4'he, 1'b0, lo};
    endfunction
    // first quadlet at the first address, second at the other, back to back
    task automatic send_pkt(input logic [31:0] q0, input logic bad);
        while (wr_ready_o !== 1'b1) tick();
        wr_i = 1'b1;
        wr_addr_i = phy_pkt_pkg::TXQ_ADDR_FIRST;
        wr_data_i = q0;
        tick();
        wr_addr_i = phy_pkt_pkg::TXQ_ADDR_SECOND;
        wr_data_i = bad ? q0 : ~q0;
        tick();
        wr_i = 1'b0;
    endtask
    // waits no longer than the reply deadline; a missing quadlet reads as unknown
    task automatic get_q(output logic [31:0] d);
        int n = 0;
        while (rx_valid_o !== 1'b1 && n < DL) begin
            tick();
            n++;
        end
        d = (rx_valid_o === 1'b1) ? rx_data_o : 'x;
        rx_ready_i = 1'b1;
        tick();
        rx_ready_i = 1'b0;
    endtask
    task automatic reply(input logic [31:0] exp, input string what);
        logic [31:0] a, b;
        get_q(a);
        get_q(b);
        chk(a, exp, what);
        chk(b, ~exp, what);
    endtask
    task automatic quiet(input string what);
        repeat (30) tick();
        chk(32'(rx_valid_o), 32'h0, what);
    endtask
    task automatic test_ping();
        logic [31:0] p;
        p = mk(6'h2a, phy_pkt_pkg::EXT_PING, 3'h0, 4'h0, 3'h0);
        send_pkt(p, 0);
        reply({2'b10, 6'h2a, 24'h5a3c81}, "ping");
        selfid_info_i = 24'h13579b;
        send_pkt(p, 0);
        reply({2'b10, 6'h2a, 24'h13579b}, "ping current");
        send_pkt(p ^ 32'h3f00_0000, 0);
        quiet("other node");
        send_pkt(p | 32'h0080_0000, 0);
        quiet("root flag");
        $display("test_ping done");
    endtask
    task automatic test_read();
        logic [31:0] p;
        logic [2:0] pg, r;
        logic [3:0] pt, a;
        for (int i = 0; i < 4; i++) begin
            pg = 3'(i + 1);
            pt = 4'(i + 2);
            r = 3'(7 - i);
            a = {i[0], r};
            p = mk(6'h2a, i[0] ? phy_pkt_pkg::EXT_PAGED_RD : phy_pkt_pkg::EXT_BASE_RD, pg, pt, r);
            send_pkt(p, 0);
            reply({12'h2a0, i[0] ? phy_pkt_pkg::EXT_PAGED_REPLY : phy_pkt_pkg::EXT_BASE_REPLY,
                pg, pt, 1'b0, pt[1:0], pg[1:0], a}, "read");
        end
        $display("test_read done");
    endtask
    task automatic test_cmd();
        logic [31:0] p;
        logic [17:0] e;
        logic [5:0] k;
        logic [2:0] c;
        logic ok;
        for (int i = 0; i < 16; i++) begin
            c = 3'(i);
            p = mk(6'h2a, phy_pkt_pkg::EXT_CMD, 3'h0, (i < 8) ? 4'h1 : 4'h3, c);
            ok = (i < 8) && c != 3'h3 && c != 3'h7;
            k = 6'(64'h0001_0204_0008_3000 >> (8 * c)); // byte per code
            e = '0;
            for (int j = 0; j < 6; j++) e[j * 3 + 1] = (i < 8) && k[j];
            acc = '0;
            send_pkt(p, 0);
            reply({p[31:20], 4'ha, p[15:8], 4'h0, ok, p[2:0]}, "confirm");
            chk(32'(acc), 32'(e), "command action");
        end
        $display("test_cmd done");
    endtask
    task automatic test_resume();
        acc = '0;
        send_pkt(mk(6'h15, phy_pkt_pkg::EXT_RESUME, 3'h0, 4'h0, 3'h0), 0);
        quiet("resume");
        chk(32'(acc), 32'h2, "resumed ports");
        $display("test_resume done");
    endtask
    task automatic test_reject();
        acc = '0;
        send_pkt(mk(6'h2a, phy_pkt_pkg::EXT_PING, 3'h0, 4'h0, 3'h0), 1);
        quiet("bad pair");
        chk(32'(acc), 32'h40000, "pair refused");
        $display("test_reject done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset for 20 cycles, then every scenario in turn
    initial begin
        repeat (20) tick();
        sys_rst_i = 1'b0;
        test_ping();
        test_read();
        test_cmd();
        test_resume();
        test_reject();
        test_done();
    end
endmodule // testbench
